// file: hdl/hdlk_pkg.sv
// constants shared by the data-link count and control block
package hdlk_pkg;
   // register byte offsets on the bus
   localparam logic [11:0] OFF_RXCNT2 = 12'h000;
   localparam logic [11:0] OFF_CTRL3 = 12'h004;
   localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
   localparam logic [11:0] OFF_IRQ_EN = 12'h00C;
   localparam logic [11:0] OFF_IRQ_CLR = 12'h010;
   localparam logic [11:0] OFF_CFG = 12'h014;
   // receive buffer window: one byte per word, 256 words
   localparam logic [1:0] BUF_WIN_TAG = 2'h1;
   // field positions
   localparam int RXCNT_PTR_BIT = 7;
   localparam int CT_AUTO_ABORT_OFF = 6;
   localparam int CT_FCS_OFF = 5;
   localparam int CT_DUP_ON = 4;
   localparam int CT_TX_ABORT = 3;
   localparam int CT_SIG_TYPE = 0;
   localparam int CFG_RX2_MOS = 0;
   localparam int IRQ_RX2_EOT = 0;
   localparam int IRQ_RX2_MSG = 1;
   localparam int IRQ_RX3_DUP = 2;
   localparam int IRQ_RX3_FCS = 3;
   // reset values and masks
   localparam logic [7:0] RXCNT2_RST = 8'h00;
   localparam logic [7:0] CTRL3_RST = 8'h00;
   localparam logic [6:0] CTRL3_MASK = 7'h7F;
   localparam logic [3:0] IRQ_RST = 4'h0;
   localparam logic [6:0] COUNT_ZERO = 7'h00;
   localparam logic [6:0] COUNT_MAX = 7'h7F;
   // ones that follow the leading zero of an automatic abort
   localparam logic [2:0] ABORT_ONES = 3'h7;
   typedef enum logic [2:0]
   {
      TX_PASS = 3'b001,
      TX_ABZ = 3'b010,
      TX_ABO = 3'b100
   } hdlk_tx_e;
endpackage

// file: hdl/hdlk_mem.sv
// two receive message buffers, one write and one registered read port
`timescale 1ns/1ps
`default_nettype none
module hdlk_mem
(
   input wire logic clk_sys,
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data
);
   logic [7:0] mem [0:255];

   always_ff @(posedge clk_sys)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      rd_data <= mem[rd_addr];
   end
endmodule
`default_nettype wire

// file: hdl/hdlk_top.sv
// data-link receive count, buffer pointer and third controller control
//
// Overview of operation
// - pointer bit names buffer with newest message
// - bit-oriented count sets repetitions before end interrupt
// - zero repetition count never raises end interrupt
// - message-oriented count reports received byte total, saturating at 127
// - byte total includes header and check bytes
// - auto abort sends zero then seven ones
// - auto abort off bit suppresses that insertion
// - receive check sequence tested unless off bit
// - duplicate discard drops frames matching held one
// - transmit abort bit forces continuous ones except for the zero of an automatic abort
// - bit zero selects bit or message signaling
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module hdlk_top
   import hdlk_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output logic IRQ,
   input wire logic RX2_BYTE_VALID,
   input wire logic [7:0] RX2_BYTE,
   input wire logic RX2_FRAME_END,
   input wire logic RX2_BOS_MSG,
   input wire logic RX3_FRAME_END,
   input wire logic RX3_FCS_OK,
   input wire logic [15:0] RX3_SIG,
   input wire logic [6:0] RX3_LEN,
   output logic RX3_KEEP,
   output logic RX3_DROP,
   input wire logic TX3_BIT_EN,
   input wire logic TX3_DATA,
   input wire logic TX3_IN_FRAME,
   output logic TX3_BIT,
   output logic TX3_HOLD,
   output logic TX3_MOS_MODE
);
   function automatic logic [3:0] sticky(input logic [3:0] cur, input logic [3:0] set,
                                         input logic [3:0] clr);
      sticky = (cur & ~clr) | set;
   endfunction

   logic newest_rx_buffer_index;
   logic [6:0] rx_message_count;
   logic [6:0] ctrl3;
   logic cfg_rx2_mos;
   logic [3:0] irq_stat;
   logic [3:0] irq_en;
   logic [3:0] irq_set;
   logic [3:0] irq_clr;
   logic d_wr;
   logic d_rd_buf;
   logic [11:0] d_addr;
   logic [31:0] rd_reg;
   logic [7:0] mem_q;
   logic a_take;
   logic sw_cnt_wr;
   logic [6:0] byte_cnt;
   logic [6:0] reps;
   logic rx_end_of_transfer_irq;
   logic mem_we;
   logic [3:0] d_wdata_lo;
   logic auto_abort_off;
   logic rx_check_sequence_off;
   logic duplicate_discard_on;
   logic tx_abort;
   logic signaling_type_select;
   logic sig_prev;
   logic abort_trig;
   hdlk_tx_e tx_state;
   hdlk_tx_e next_tx_state;
   logic [2:0] ones_cnt;
   logic have_last;
   logic [15:0] last_sig;
   logic [6:0] last_len;
   logic is_dup;
   logic fcs_bad;

   assign auto_abort_off = ctrl3[CT_AUTO_ABORT_OFF];
   assign rx_check_sequence_off = ctrl3[CT_FCS_OFF];
   assign duplicate_discard_on = ctrl3[CT_DUP_ON];
   assign tx_abort = ctrl3[CT_TX_ABORT];
   assign signaling_type_select = ctrl3[CT_SIG_TYPE];

   // bus slave: zero wait states, always OKAY
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign a_take = HSEL && HTRANS[1] && HREADY;
   assign d_wdata_lo = HWDATA[3:0];

   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         d_wr <= 1'b0;
         d_rd_buf <= 1'b0;
         d_addr <= 12'h000;
      end
      else
      begin
         d_wr <= a_take && HWRITE;
         d_rd_buf <= a_take && !HWRITE && (HADDR[11:10] == BUF_WIN_TAG);
         d_addr <= HADDR[11:0];
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         rd_reg <= 32'h0000_0000;
      end
      else if (a_take && !HWRITE)
      begin
         case (HADDR[11:0])
            OFF_RXCNT2: rd_reg <= {24'h000000, newest_rx_buffer_index, rx_message_count};
            OFF_CTRL3: rd_reg <= {25'h0000000, ctrl3};
            OFF_IRQ_STAT: rd_reg <= {28'h0000000, irq_stat};
            OFF_IRQ_EN: rd_reg <= {28'h0000000, irq_en};
            OFF_CFG: rd_reg <= {31'h00000000, cfg_rx2_mos};
            default: rd_reg <= 32'h0000_0000;
         endcase
      end
   end

   assign HRDATA = d_rd_buf ? {24'h000000, mem_q} : rd_reg;

   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         ctrl3 <= CTRL3_RST[6:0];
         cfg_rx2_mos <= 1'b0;
         irq_en <= IRQ_RST;
      end
      else if (d_wr)
      begin
         // reserved top bit is not stored and reads zero
         if (d_addr == OFF_CTRL3)
         begin
            ctrl3 <= HWDATA[6:0] & CTRL3_MASK;
         end
         if (d_addr == OFF_CFG)
         begin
            cfg_rx2_mos <= HWDATA[CFG_RX2_MOS];
         end
         if (d_addr == OFF_IRQ_EN)
         begin
            irq_en <= d_wdata_lo;
         end
      end
   end

   // receive controller two: bytes go to the buffer that is not newest
   assign sw_cnt_wr = d_wr && (d_addr == OFF_RXCNT2);
   assign mem_we = RX2_BYTE_VALID && cfg_rx2_mos && (byte_cnt != COUNT_MAX);

   hdlk_mem u_mem
   (
      .clk_sys(CLK_SYS),
      .wr_en(mem_we),
      .wr_addr({!newest_rx_buffer_index, byte_cnt}),
      .wr_data(RX2_BYTE),
      .rd_addr(HADDR[9:2]),
      .rd_data(mem_q)
   );

   // every byte delivered in message mode up to 127 counts, header and check bytes alike
   always_ff @(posedge CLK_SYS)
   begin
      if (RST || RX2_FRAME_END)
      begin
         byte_cnt <= COUNT_ZERO;
      end
      else if (mem_we)
      begin
         byte_cnt <= byte_cnt + 7'h01;
      end
   end

   // hardware update wins over a software write in the same cycle
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         newest_rx_buffer_index <= RXCNT2_RST[RXCNT_PTR_BIT];
         rx_message_count <= RXCNT2_RST[6:0];
      end
      else if (RX2_FRAME_END && cfg_rx2_mos)
      begin
         newest_rx_buffer_index <= !newest_rx_buffer_index;
         rx_message_count <= byte_cnt;
      end
      else if (sw_cnt_wr)
      begin
         newest_rx_buffer_index <= HWDATA[RXCNT_PTR_BIT];
         rx_message_count <= HWDATA[6:0];
      end
   end

   // bit-oriented repetitions, the count field holds the target
   assign rx_end_of_transfer_irq = RX2_BOS_MSG && !cfg_rx2_mos
      && (rx_message_count != COUNT_ZERO)
      && (reps == rx_message_count - 7'h01);

   always_ff @(posedge CLK_SYS)
   begin
      if (RST || cfg_rx2_mos || sw_cnt_wr || rx_end_of_transfer_irq)
      begin
         reps <= COUNT_ZERO;
      end
      else if (RX2_BOS_MSG && reps != COUNT_MAX)
      begin
         reps <= reps + 7'h01;
      end
   end

   // receive controller three: check sequence and duplicate filter
   assign fcs_bad = !rx_check_sequence_off && !RX3_FCS_OK;
   assign is_dup = duplicate_discard_on && have_last && (RX3_SIG == last_sig)
      && (RX3_LEN == last_len);

   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         RX3_KEEP <= 1'b0;
         RX3_DROP <= 1'b0;
      end
      else
      begin
         RX3_KEEP <= RX3_FRAME_END && !fcs_bad && !is_dup;
         RX3_DROP <= RX3_FRAME_END && (fcs_bad || is_dup);
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         have_last <= 1'b0;
         last_sig <= 16'h0000;
         last_len <= COUNT_ZERO;
      end
      else if (RX3_FRAME_END && !fcs_bad && !is_dup)
      begin
         have_last <= 1'b1;
         last_sig <= RX3_SIG;
         last_len <= RX3_LEN;
      end
   end

   // interrupts: set beats clear in the same cycle
   assign irq_set = {RX3_FRAME_END && fcs_bad, RX3_FRAME_END && !fcs_bad && is_dup,
                     RX2_FRAME_END && cfg_rx2_mos, rx_end_of_transfer_irq};
   assign irq_clr = (d_wr && d_addr == OFF_IRQ_CLR) ? d_wdata_lo : 4'h0;

   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         irq_stat <= IRQ_RST;
      end
      else
      begin
         irq_stat <= sticky(irq_stat, irq_set, irq_clr);
      end
   end

   assign IRQ = |(irq_stat & irq_en);

   // transmit controller three
   assign TX3_MOS_MODE = signaling_type_select;
   assign abort_trig = sig_prev && !signaling_type_select && TX3_IN_FRAME
      && !auto_abort_off;

   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         sig_prev <= 1'b0;
      end
      else
      begin
         sig_prev <= signaling_type_select;
      end
   end

   always_comb
   begin
      next_tx_state = tx_state;
      case (tx_state)
         TX_PASS:
         begin
            if (abort_trig)
            begin
               next_tx_state = TX_ABZ;
            end
         end
         TX_ABZ:
         begin
            if (TX3_BIT_EN)
            begin
               next_tx_state = TX_ABO;
            end
         end
         TX_ABO:
         begin
            if (TX3_BIT_EN && ones_cnt == ABORT_ONES - 3'h1)
            begin
               next_tx_state = TX_PASS;
            end
         end
         default: next_tx_state = TX_PASS;
      endcase
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         tx_state <= TX_PASS;
      end
      else
      begin
         tx_state <= next_tx_state;
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RST || tx_state != TX_ABO)
      begin
         ones_cnt <= 3'h0;
      end
      else if (TX3_BIT_EN)
      begin
         ones_cnt <= ones_cnt + 3'h1;
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         TX3_BIT <= 1'b1;
      end
      else if (TX3_BIT_EN)
      begin
         case (tx_state)
            TX_ABZ: TX3_BIT <= 1'b0;
            TX_ABO: TX3_BIT <= 1'b1;
            default: TX3_BIT <= tx_abort ? 1'b1 : TX3_DATA;
         endcase
      end
   end

   assign TX3_HOLD = (tx_state != TX_PASS);

   // checks
   property p_ptr;
      @(posedge CLK_SYS) disable iff (RST)
      RX2_FRAME_END && cfg_rx2_mos |=> newest_rx_buffer_index != $past(newest_rx_buffer_index);
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer did not flip");

   property p_cnt;
      @(posedge CLK_SYS) disable iff (RST)
      RX2_FRAME_END && cfg_rx2_mos |=> rx_message_count == $past(byte_cnt) && byte_cnt == 7'h00;
   endproperty
   a_cnt: assert property (p_cnt) else $error("count not latched at end");

   property p_bytes;
      @(posedge CLK_SYS) disable iff (RST)
      mem_we && !RX2_FRAME_END |=> byte_cnt == $past(byte_cnt) + 7'h01;
   endproperty
   a_bytes: assert property (p_bytes) else $error("byte not counted");

   property p_eot;
      @(posedge CLK_SYS) disable iff (RST)
      RX2_BOS_MSG && !cfg_rx2_mos && rx_message_count != 7'h00
      && reps == rx_message_count - 7'h01 |=> irq_stat[IRQ_RX2_EOT] && reps == 7'h00;
   endproperty
   a_eot: assert property (p_eot) else $error("end interrupt missing");

   property p_noeot;
      @(posedge CLK_SYS) disable iff (RST)
      rx_message_count == 7'h00 |-> !rx_end_of_transfer_irq;
   endproperty
   a_noeot: assert property (p_noeot) else $error("end raised with zero count");

   property p_abort;
      @(posedge CLK_SYS) disable iff (RST)
      tx_state == TX_ABZ && TX3_BIT_EN |=> !TX3_BIT && tx_state == TX_ABO;
   endproperty
   a_abort: assert property (p_abort) else $error("abort zero missing");

   property p_noauto;
      @(posedge CLK_SYS) disable iff (RST)
      auto_abort_off && tx_state == TX_PASS |=> tx_state != TX_ABZ;
   endproperty
   a_noauto: assert property (p_noauto) else $error("abort despite off bit");

   property p_fcs;
      @(posedge CLK_SYS) disable iff (RST)
      RX3_FRAME_END && !rx_check_sequence_off && !RX3_FCS_OK |=> RX3_DROP && !RX3_KEEP;
   endproperty
   a_fcs: assert property (p_fcs) else $error("bad frame kept");

   property p_dup;
      @(posedge CLK_SYS) disable iff (RST)
      RX3_FRAME_END && !duplicate_discard_on && (rx_check_sequence_off || RX3_FCS_OK)
      |=> RX3_KEEP;
   endproperty
   a_dup: assert property (p_dup) else $error("frame dropped with discard off");

   property p_txab;
      @(posedge CLK_SYS) disable iff (RST)
      tx_abort && tx_state == TX_PASS && TX3_BIT_EN |=> TX3_BIT;
   endproperty
   a_txab: assert property (p_txab) else $error("abort ones not sent");

   c_msg: cover property (@(posedge CLK_SYS) disable iff (RST) RX2_FRAME_END && cfg_rx2_mos);
   c_eot: cover property (@(posedge CLK_SYS) disable iff (RST) rx_end_of_transfer_irq);
   c_auto: cover property (@(posedge CLK_SYS) disable iff (RST) abort_trig);
   c_dup: cover property (@(posedge CLK_SYS) disable iff (RST) RX3_FRAME_END && is_dup);
endmodule
`default_nettype wire

// file: tb/hdlk_far.sv
// far-side terminal model: feeds received traffic and clocks out transmit bits
`timescale 1ns/1ps
`default_nettype none
module hdlk_far
(
   input wire logic clk,
   input wire logic tx3_bit,
   input wire logic rx3_keep,
   input wire logic rx3_drop,
   output logic rx2_byte_valid,
   output logic [7:0] rx2_byte,
   output logic rx2_frame_end,
   output logic rx2_bos_msg,
   output logic rx3_frame_end,
   output logic rx3_fcs_ok,
   output logic [15:0] rx3_sig,
   output logic [6:0] rx3_len,
   output logic tx3_bit_en
);
   initial
   begin
      rx2_byte_valid = 1'b0;
      rx2_byte = 8'h00;
      rx2_frame_end = 1'b0;
      rx2_bos_msg = 1'b0;
      rx3_frame_end = 1'b0;
      rx3_fcs_ok = 1'b0;
      rx3_sig = 16'h0000;
      rx3_len = 7'h00;
      tx3_bit_en = 1'b0;
   end
   // whole frame of n bytes, header and check bytes included
   task automatic msg(input int n, input logic [7:0] base);
      for (int k = 0; k < n; k++)
      begin
         rx2_byte_valid <= 1'b1;
         rx2_byte <= base + 8'(k);
         @(posedge clk);
      end
      rx2_byte_valid <= 1'b0;
      rx2_byte <= ~rx2_byte;
      rx2_frame_end <= 1'b1;
      @(posedge clk);
      rx2_frame_end <= 1'b0;
      @(posedge clk);
   endtask
   task automatic bit_oriented_signaling();
      rx2_bos_msg <= 1'b1;
      @(posedge clk);
      rx2_bos_msg <= 1'b0;
      @(posedge clk);
   endtask
   // one third-receiver frame; returns keep and drop seen the cycle after
   task automatic f3(input logic [15:0] sig, input logic ok, output logic [1:0] kd);
      rx3_frame_end <= 1'b1;
      rx3_fcs_ok <= ok;
      rx3_sig <= sig;
      rx3_len <= 7'h05;
      @(posedge clk);
      rx3_frame_end <= 1'b0;
      rx3_fcs_ok <= ~ok;
      rx3_sig <= ~sig;
      @(posedge clk);
      kd = {rx3_keep, rx3_drop};
   endtask
   // eight bit strobes, first bit ends up most significant
   task automatic tx_byte(output logic [7:0] b);
      for (int k = 0; k < 8; k++)
      begin
         tx3_bit_en <= 1'b1;
         @(posedge clk);
         tx3_bit_en <= 1'b0;
         @(posedge clk);
         b = {b[6:0], tx3_bit};
      end
   endtask
endmodule
`default_nettype wire

// file: tb/hdlk_top_tb.sv
// self-checking bench: register access over the bus plus far-side traffic
`timescale 1ns/1ps
`default_nettype none
module hdlk_top_tb;
   import hdlk_pkg::*;
   logic CLK_SYS = 1'b0;
   logic RST, HSEL, HWRITE, TX3_DATA, TX3_IN_FRAME;
   logic [31:0] HADDR, HWDATA, HRDATA;
   logic [1:0] HTRANS;
   logic HREADYOUT, HRESP, IRQ, RX3_KEEP, RX3_DROP, TX3_BIT, TX3_HOLD, TX3_MOS_MODE;
   logic RX2_BYTE_VALID, RX2_FRAME_END, RX2_BOS_MSG, RX3_FRAME_END, RX3_FCS_OK, TX3_BIT_EN;
   logic [7:0] RX2_BYTE;
   logic [15:0] RX3_SIG;
   logic [6:0] RX3_LEN;
   int n_fail = 0;
   int check_count = 0;
   always #10 CLK_SYS = ~CLK_SYS;
   hdlk_top u_dut (.CLK_SYS(CLK_SYS), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA),
      .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
      .IRQ(IRQ), .RX2_BYTE_VALID(RX2_BYTE_VALID), .RX2_BYTE(RX2_BYTE),
      .RX2_FRAME_END(RX2_FRAME_END), .RX2_BOS_MSG(RX2_BOS_MSG),
      .RX3_FRAME_END(RX3_FRAME_END), .RX3_FCS_OK(RX3_FCS_OK), .RX3_SIG(RX3_SIG),
      .RX3_LEN(RX3_LEN), .RX3_KEEP(RX3_KEEP), .RX3_DROP(RX3_DROP),
      .TX3_BIT_EN(TX3_BIT_EN), .TX3_DATA(TX3_DATA), .TX3_IN_FRAME(TX3_IN_FRAME),
      .TX3_BIT(TX3_BIT), .TX3_HOLD(TX3_HOLD), .TX3_MOS_MODE(TX3_MOS_MODE));
   hdlk_far u_far (.clk(CLK_SYS), .tx3_bit(TX3_BIT), .rx3_keep(RX3_KEEP),
      .rx3_drop(RX3_DROP), .rx2_byte_valid(RX2_BYTE_VALID), .rx2_byte(RX2_BYTE),
      .rx2_frame_end(RX2_FRAME_END), .rx2_bos_msg(RX2_BOS_MSG),
      .rx3_frame_end(RX3_FRAME_END), .rx3_fcs_ok(RX3_FCS_OK), .rx3_sig(RX3_SIG),
      .rx3_len(RX3_LEN), .tx3_bit_en(TX3_BIT_EN));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // single transfer, then one idle cycle so a following read sees the write
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
      HSEL <= 1'b1;
      HTRANS <= 2'b10;
      HADDR <= {20'h00000, a};
      HWRITE <= w;
      do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'b00;
      HWDATA <= d;
      do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
      q = HRDATA;
      @(posedge CLK_SYS);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(nm, q, e);
   endtask
   task automatic give_verdict();
      if (n_fail == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      #100000;
      n_fail++;
      give_verdict();
   end
   initial
   begin
      logic [1:0] kd;
      logic [7:0] b;
      RST = 1'b1;
      HSEL = 1'b0;
      HADDR = 32'h0;
      HTRANS = 2'b00;
      HWRITE = 1'b0;
      HWDATA = 32'h0;
      TX3_DATA = 1'b0;
      TX3_IN_FRAME = 1'b1;
      repeat (20) @(posedge CLK_SYS);
      RST <= 1'b0;
      @(posedge CLK_SYS);
      // ready, response, interrupt, receive pulses and transmit pins after reset
      chk("outputs rst", {24'h0, HREADYOUT, HRESP, IRQ, RX3_KEEP, RX3_DROP, TX3_BIT, TX3_HOLD,
         TX3_MOS_MODE}, 32'h84);
      rd("count rst", OFF_RXCNT2, 32'h00);
      rd("ctrl rst", OFF_CTRL3, 32'h00);
      rd("unmapped", 12'h020, 32'h00);
      wr(OFF_CTRL3, 32'h36);
      rd("ctrl rw", OFF_CTRL3, 32'h36);
      wr(OFF_CTRL3, 32'h00);
      // message mode: pointer flips, count covers all bytes up to 127
      wr(OFF_CFG, 32'h1);
      wr(OFF_IRQ_EN, 32'h2);
      u_far.msg(5, 8'hA0);
      rd("count 1", OFF_RXCNT2, 32'h85);
      rd("buf1 b0", 12'h600, 32'hA0);
      chk("irq msg", {31'h0, IRQ}, 32'h1);
      u_far.msg(3, 8'h50);
      rd("count 2", OFF_RXCNT2, 32'h03);
      rd("buf0 b2", 12'h408, 32'h52);
      u_far.msg(130, 8'h00);
      rd("count sat", OFF_RXCNT2, 32'hFF);
      wr(OFF_IRQ_EN, 32'h0);
      chk("irq mask", {31'h0, IRQ}, 32'h0);
      wr(OFF_IRQ_CLR, 32'hF);
      rd("stat clr", OFF_IRQ_STAT, 32'h0);
      // bit mode repetitions
      wr(OFF_CFG, 32'h0);
      wr(OFF_RXCNT2, 32'h3);
      wr(OFF_IRQ_EN, 32'h1);
      repeat (2) u_far.bit_oriented_signaling();
      chk("eot early", {31'h0, IRQ}, 32'h0);
      u_far.bit_oriented_signaling();
      chk("eot third", {31'h0, IRQ}, 32'h1);
      rd("stat eot", OFF_IRQ_STAT, 32'h1);
      wr(OFF_IRQ_CLR, 32'h1);
      wr(OFF_RXCNT2, 32'h0);
      repeat (4) u_far.bit_oriented_signaling();
      chk("eot never", {31'h0, IRQ}, 32'h0);
      // third receiver checks and discards
      u_far.f3(16'h1234, 1'b0, kd);
      chk("fcs bad", {30'h0, kd}, 32'h1);
      u_far.f3(16'h1234, 1'b1, kd);
      chk("keep a", {30'h0, kd}, 32'h2);
      u_far.f3(16'h1234, 1'b1, kd);
      chk("dup off", {30'h0, kd}, 32'h2);
      wr(OFF_CTRL3, 32'h10);
      u_far.f3(16'h1234, 1'b1, kd);
      chk("dup on", {30'h0, kd}, 32'h1);
      wr(OFF_CTRL3, 32'h30);
      u_far.f3(16'h5678, 1'b0, kd);
      chk("fcs off", {30'h0, kd}, 32'h2);
      rd("stat rx3", OFF_IRQ_STAT, 32'hC);
      // third transmitter
      wr(OFF_CTRL3, 32'h01);
      @(posedge CLK_SYS);
      chk("mos mode", {31'h0, TX3_MOS_MODE}, 32'h1);
      wr(OFF_CTRL3, 32'h00);
      @(posedge CLK_SYS);
      chk("hold", {31'h0, TX3_HOLD}, 32'h1);
      u_far.tx_byte(b);
      chk("auto abort", {24'h0, b}, 32'h7F);
      u_far.tx_byte(b);
      chk("pass", {24'h0, b}, 32'h00);
      wr(OFF_CTRL3, 32'h41);
      wr(OFF_CTRL3, 32'h40);
      @(posedge CLK_SYS);
      chk("no hold", {31'h0, TX3_HOLD}, 32'h0);
      TX3_DATA <= 1'b1;
      u_far.tx_byte(b);
      chk("no abort", {24'h0, b}, 32'hFF);
      // a switch outside a frame needs no abort
      TX3_DATA <= 1'b0;
      TX3_IN_FRAME <= 1'b0;
      wr(OFF_CTRL3, 32'h01);
      wr(OFF_CTRL3, 32'h00);
      @(posedge CLK_SYS);
      chk("idle switch", {31'h0, TX3_HOLD}, 32'h0);
      TX3_IN_FRAME <= 1'b1;
      wr(OFF_CTRL3, 32'h08);
      u_far.tx_byte(b);
      chk("tx abort", {24'h0, b}, 32'hFF);
      wr(OFF_CTRL3, 32'h00);
      u_far.tx_byte(b);
      chk("tx normal", {24'h0, b}, 32'h00);
      give_verdict();
   end
endmodule
`default_nettype wire
